// ### rtl/fan_regs.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "fan_defines.svh"

// Operation
// - Identification register returns constant read-only fields
// - Advertisement layout applies in 1000BASE-X mode
// - Written fields stay pending until apply event
// - Next page bit, hardware reset 0, retained
// - Remote fault code written by software, reset 00
// - Pause bits encode pause advertisement
// - Pause bits load strap on hardware reset
// - Half duplex bit loads autoneg strap bit
// - Full duplex bit resets to one, retained
module fan_regs
    import fan_pkg::*;
#(
    parameter logic [5:0] OUI_LSB = 6'h2a,
    parameter logic [5:0] MODEL_NUM = 6'h15,
    parameter logic [3:0] REV_NUM = 4'h5
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Register port
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Configuration straps
    input wire logic pause_strap_default,
    input wire logic autoneg_config_strap_bit0,
    // Link state
    input wire logic link_up,
    // Advertisement and control toward the negotiation logic
    output logic [15:0] adv_effective,
    output logic [1:0] media_mode,
    output logic power_down,
    output logic sw_reset_pulse,
    output logic an_restart_pulse,
    output logic adv_apply_pulse
);

    ////////////////////////////////////////////////////////////////////////////

    function automatic logic fan_hit(input logic [4:0] addr, input logic [4:0] off);
        fan_hit = (addr == off);
    endfunction

    // Places the stored advertisement fields at their register bit positions.
    // The reserved bits 14 and 11:9 have no storage and stay zero.
    function automatic logic [15:0] fan_pack_adv(
        input logic np,
        input logic [1:0] rf,
        input logic [1:0] pause,
        input logic hd,
        input logic fd,
        input logic [4:0] rsv
    );
        fan_pack_adv = 16'h0000;
        fan_pack_adv[`FAN_ADV_NP] = np;
        fan_pack_adv[`FAN_ADV_RF_HI:`FAN_ADV_RF_LO] = rf;
        fan_pack_adv[`FAN_ADV_PAUSE_HI:`FAN_ADV_PAUSE_LO] = pause;
        fan_pack_adv[`FAN_ADV_HD] = hd;
        fan_pack_adv[`FAN_ADV_FD] = fd;
        fan_pack_adv[`FAN_ADV_RSV_HI:`FAN_ADV_RSV_LO] = rsv;
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    // Control, mode, read data and event pulses; the advertisement fields have their own flops.
    fan_state_t st_r;
    fan_state_t st_nxt;

    // Decoded writes and the apply events that they raise.
    logic wr_ctrl;
    logic wr_adv;
    logic wr_mode;
    logic swrst_now;
    logic restart_now;
    logic pd_exit_now;
    logic link_down_now;
    logic apply_now;
    logic mode_bx;

    // Pending copy for software and effective copy for negotiation, per field.
    logic np_pend;
    logic np_eff;
    logic [1:0] rf_pend;
    logic [1:0] rf_eff;
    logic [1:0] pause_pend;
    logic [1:0] pause_eff;
    logic hd_pend;
    logic hd_eff;
    logic fd_pend;
    logic fd_eff;
    logic [4:0] rsv_pend;
    logic [4:0] rsv_eff;

    // Words assembled for the read mux and for the negotiation logic.
    logic [15:0] id_word;
    logic [15:0] adv_word;
    logic [15:0] ctrl_word;
    logic [15:0] mode_word;
    logic [15:0] eff_word;

    ////////////////////////////////////////////////////////////////////////////

    // Write decode.
    assign wr_ctrl = reg_wr && fan_hit(reg_addr, `FAN_OFF_CTRL);
    assign wr_mode = reg_wr && fan_hit(reg_addr, `FAN_OFF_MODE);
    assign mode_bx = (st_r.mode == FAN_MODE_1000BX);
    // Other media modes give this offset another layout, so writes are dropped there.
    assign wr_adv = reg_wr && fan_hit(reg_addr, `FAN_OFF_ADV) && mode_bx;

    // Events that move the pending advertisement into effect.
    assign swrst_now = wr_ctrl && reg_wdata[`FAN_CTRL_SWRST];
    assign restart_now = wr_ctrl && reg_wdata[`FAN_CTRL_RESTART];
    // Leaving power-down counts only when the bit was set before this write.
    assign pd_exit_now = wr_ctrl && st_r.pdown && !reg_wdata[`FAN_CTRL_PDOWN];
    // The link sampler resets low, so a link that is down when reset ends
    // is not taken as a drop.
    assign link_down_now = st_r.link_q && !link_up;
    assign apply_now = swrst_now || restart_now || pd_exit_now || link_down_now;

    ////////////////////////////////////////////////////////////////////////////

    // Writable advertisement fields.
    fan_adv_field #(
        .W(1),
        .SW_CLR(1'b0),
        .SW_VAL(1'b0)
    ) u_np (
        .core_clk(core_clk),
        .srst(srst),
        .hw_val(`FAN_RST_NP),
        .sw_reset(swrst_now),
        .apply(apply_now),
        .wr_en(wr_adv),
        .wr_val(reg_wdata[`FAN_ADV_NP]),
        .pending(np_pend),
        .effective(np_eff)
    );

    fan_adv_field #(
        .W(2),
        .SW_CLR(1'b0),
        .SW_VAL(2'h0)
    ) u_rf (
        .core_clk(core_clk),
        .srst(srst),
        .hw_val(`FAN_RST_RF),
        .sw_reset(swrst_now),
        .apply(apply_now),
        .wr_en(wr_adv),
        .wr_val(reg_wdata[`FAN_ADV_RF_HI:`FAN_ADV_RF_LO]),
        .pending(rf_pend),
        .effective(rf_eff)
    );

    fan_adv_field #(
        .W(2),
        .SW_CLR(1'b0),
        .SW_VAL(2'h0)
    ) u_pause (
        .core_clk(core_clk),
        .srst(srst),
        // Both pause bits take the one pause strap on hardware reset.
        .hw_val({pause_strap_default, pause_strap_default}),
        .sw_reset(swrst_now),
        .apply(apply_now),
        .wr_en(wr_adv),
        .wr_val(reg_wdata[`FAN_ADV_PAUSE_HI:`FAN_ADV_PAUSE_LO]),
        .pending(pause_pend),
        .effective(pause_eff)
    );

    fan_adv_field #(
        .W(1),
        .SW_CLR(1'b0),
        .SW_VAL(1'b0)
    ) u_hd (
        .core_clk(core_clk),
        .srst(srst),
        // Half duplex follows bit 0 of the autoneg strap on hardware reset.
        .hw_val(autoneg_config_strap_bit0),
        .sw_reset(swrst_now),
        .apply(apply_now),
        .wr_en(wr_adv),
        .wr_val(reg_wdata[`FAN_ADV_HD]),
        .pending(hd_pend),
        .effective(hd_eff)
    );

    fan_adv_field #(
        .W(1),
        .SW_CLR(1'b0),
        .SW_VAL(1'b0)
    ) u_fd (
        .core_clk(core_clk),
        .srst(srst),
        .hw_val(`FAN_RST_FD),
        .sw_reset(swrst_now),
        .apply(apply_now),
        .wr_en(wr_adv),
        .wr_val(reg_wdata[`FAN_ADV_FD]),
        .pending(fd_pend),
        .effective(fd_eff)
    );

    // The low reserved bits hold what is written but clear on either reset.
    fan_adv_field #(
        .W(5),
        .SW_CLR(1'b1),
        .SW_VAL(`FAN_RST_RSV)
    ) u_rsv (
        .core_clk(core_clk),
        .srst(srst),
        .hw_val(`FAN_RST_RSV),
        .sw_reset(swrst_now),
        .apply(apply_now),
        .wr_en(wr_adv),
        .wr_val(reg_wdata[`FAN_ADV_RSV_HI:`FAN_ADV_RSV_LO]),
        .pending(rsv_pend),
        .effective(rsv_eff)
    );

    ////////////////////////////////////////////////////////////////////////////

    // Read words.
    always_comb
    begin
        id_word = 16'h0000;
        id_word[`FAN_ID_OUI_HI:`FAN_ID_OUI_LO] = OUI_LSB;
        id_word[`FAN_ID_MODEL_HI:`FAN_ID_MODEL_LO] = MODEL_NUM;
        id_word[`FAN_ID_REV_HI:`FAN_ID_REV_LO] = REV_NUM;
    end

    // Software reads back the pending copy.
    always_comb
    begin
        adv_word = fan_pack_adv(np_pend, rf_pend, pause_pend, hd_pend, fd_pend, rsv_pend);
    end

    // The negotiation logic only ever sees the applied copy.
    always_comb
    begin
        eff_word = fan_pack_adv(np_eff, rf_eff, pause_eff, hd_eff, fd_eff, rsv_eff);
    end

    // Reset and restart are self-clearing and read as zero.
    always_comb
    begin
        ctrl_word = 16'h0000;
        ctrl_word[`FAN_CTRL_PDOWN] = st_r.pdown;
        mode_word = {14'h0000, st_r.mode};
    end

    ////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.link_q = link_up;
        st_nxt.swrst_pulse = swrst_now;
        st_nxt.restart_pulse = restart_now;
        st_nxt.apply_pulse = apply_now;
        if (wr_ctrl)
        begin
            st_nxt.pdown = reg_wdata[`FAN_CTRL_PDOWN];
        end
        // A software reset always leaves power-down, whatever bit 11 holds.
        if (swrst_now)
        begin
            st_nxt.pdown = `FAN_RST_PDOWN;
        end
        // The mode takes effect at once; only the advertisement waits for an apply.
        if (wr_mode)
        begin
            st_nxt.mode = fan_media_t'(reg_wdata[1:0]);
        end
        // Read data stand only in the cycle after the strobe.
        st_nxt.rd_data = 16'h0000;
        if (reg_rd)
        begin
            case (reg_addr)
                `FAN_OFF_CTRL:
                begin
                    st_nxt.rd_data = ctrl_word;
                end
                `FAN_OFF_ID:
                begin
                    st_nxt.rd_data = id_word;
                end
                `FAN_OFF_ADV:
                begin
                    // Other modes read zero rather than a layout this block does not hold.
                    if (mode_bx)
                    begin
                        st_nxt.rd_data = adv_word;
                    end
                end
                `FAN_OFF_MODE:
                begin
                    st_nxt.rd_data = mode_word;
                end
                default:
                begin
                    st_nxt.rd_data = 16'h0000;
                end
            endcase
        end
    end

    // The advertisement fields reset inside their own flops.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            st_r.rd_data <= 16'h0000;
            st_r.pdown <= `FAN_RST_PDOWN;
            st_r.mode <= fan_media_t'(`FAN_RST_MODE);
            st_r.link_q <= 1'b0;
            st_r.swrst_pulse <= 1'b0;
            st_r.restart_pulse <= 1'b0;
            st_r.apply_pulse <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Every output is a flop or a fixed packing of flops.
    assign reg_rdata = st_r.rd_data;
    assign adv_effective = eff_word;
    assign media_mode = st_r.mode;
    assign power_down = st_r.pdown;
    assign sw_reset_pulse = st_r.swrst_pulse;
    assign an_restart_pulse = st_r.restart_pulse;
    assign adv_apply_pulse = st_r.apply_pulse;

endmodule

// ### rtl/fan_defines.svh
`ifndef FAN_DEFINES_SVH
`define FAN_DEFINES_SVH

// Register offsets on the management port.
`define FAN_OFF_CTRL 5'h00
`define FAN_OFF_ID 5'h03
`define FAN_OFF_ADV 5'h04
`define FAN_OFF_MODE 5'h10

// Control register fields.
`define FAN_CTRL_SWRST 15
`define FAN_CTRL_PDOWN 11
`define FAN_CTRL_RESTART 9

// Identification register fields.
`define FAN_ID_OUI_HI 15
`define FAN_ID_OUI_LO 10
`define FAN_ID_MODEL_HI 9
`define FAN_ID_MODEL_LO 4
`define FAN_ID_REV_HI 3
`define FAN_ID_REV_LO 0

// Advertisement register fields.
`define FAN_ADV_NP 15
`define FAN_ADV_RF_HI 13
`define FAN_ADV_RF_LO 12
`define FAN_ADV_PAUSE_HI 8
`define FAN_ADV_PAUSE_LO 7
`define FAN_ADV_HD 6
`define FAN_ADV_FD 5
`define FAN_ADV_RSV_HI 4
`define FAN_ADV_RSV_LO 0

// Reset values.
`define FAN_RST_NP 1'h0
`define FAN_RST_RF 2'h0
`define FAN_RST_FD 1'h1
`define FAN_RST_RSV 5'h00
`define FAN_RST_MODE 2'h1
`define FAN_RST_PDOWN 1'h0

`endif

// ### rtl/fan_pkg.sv
package fan_pkg;

    typedef enum logic [1:0] {
        FAN_MODE_COPPER = 2'b00,
        FAN_MODE_1000BX = 2'b01,
        FAN_MODE_SGMII_SYS = 2'b10,
        FAN_MODE_SGMII_MED = 2'b11
    } fan_media_t;

    typedef struct packed {
        logic [15:0] rd_data;
        logic pdown;
        fan_media_t mode;
        logic link_q;
        logic swrst_pulse;
        logic restart_pulse;
        logic apply_pulse;
    } fan_state_t;

endpackage

// ### rtl/fan_adv_field.sv
`timescale 1ns/1ps

// One writable advertisement field: a pending copy that software sees and
// an effective copy that only follows the pending one on an apply event.
module fan_adv_field #(
    parameter int W = 1,
    parameter bit SW_CLR = 1'b0,
    parameter logic [W-1:0] SW_VAL = '0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Defaults and events
    input wire logic [W-1:0] hw_val,
    input wire logic sw_reset,
    input wire logic apply,
    // Software write
    input wire logic wr_en,
    input wire logic [W-1:0] wr_val,
    // Field values
    output logic [W-1:0] pending,
    output logic [W-1:0] effective
);

    typedef struct packed {
        logic [W-1:0] pend;
        logic [W-1:0] eff;
    } fan_fld_t;

    fan_fld_t st_r;
    fan_fld_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (wr_en)
        begin
            st_nxt.pend = wr_val;
        end
        if (apply)
        begin
            st_nxt.eff = st_r.pend;
        end
        if (sw_reset && SW_CLR)
        begin
            st_nxt.pend = SW_VAL;
            st_nxt.eff = SW_VAL;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            st_r.pend <= hw_val;
            st_r.eff <= hw_val;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign pending = st_r.pend;
    assign effective = st_r.eff;

endmodule

// ### dv/fan_regs_checker.sv
`timescale 1ns/1ps

module fan_regs_checker #(
    parameter logic [5:0] OUI_LSB = 6'h2a,
    parameter logic [5:0] MODEL_NUM = 6'h15,
    parameter logic [3:0] REV_NUM = 4'h5
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Register port
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Straps and link
    input wire logic pause_strap_default,
    input wire logic autoneg_config_strap_bit0,
    input wire logic link_up,
    // Outputs under watch
    input wire logic [15:0] adv_effective,
    input wire logic [1:0] media_mode,
    input wire logic power_down,
    input wire logic sw_reset_pulse,
    input wire logic an_restart_pulse,
    input wire logic adv_apply_pulse
);
    ////////////////////////////////////////////////////////////////////////
    // Any apply event seen at an edge must show as a pulse one cycle later.
    logic ev_r;
    logic link_r;
    logic ev_nxt;
    assign ev_nxt = (reg_wr && reg_addr == 5'h00 && (reg_wdata[15] || reg_wdata[9]
        || (!reg_wdata[11] && power_down))) || (link_r && !link_up);
    always_ff @(posedge core_clk)
    begin
        ev_r <= srst ? 1'b0 : ev_nxt;
        link_r <= srst ? 1'b0 : link_up;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    a_id_constant: assert property (reg_rd && reg_addr == 5'h03
        |=> reg_rdata == {OUI_LSB, MODEL_NUM, REV_NUM}) else $error("identity word wrong");
    a_mode_gate_adv: assert property (reg_rd && reg_addr == 5'h04
        && media_mode != 2'b01 |=> reg_rdata == 16'h0000) else $error("adv read not gated");
    a_pending_readback: assert property (reg_wr && reg_addr == 5'h04
        && media_mode == 2'b01 ##1 !reg_wr ##1 reg_rd && reg_addr == 5'h04
        |=> reg_rdata == ($past(reg_wdata, 3) & 16'hb1ff)) else $error("adv readback wrong");
    a_apply_cause: assert property (adv_apply_pulse == ev_r)
        else $error("apply pulse without matching event");
    a_hold_between: assert property (!adv_apply_pulse |-> $stable(adv_effective))
        else $error("effective word moved without apply");
    a_reserved_zero: assert property (adv_effective[14] == 1'b0
        && adv_effective[11:9] == 3'h0) else $error("reserved bits set");
    a_swrst_low_clear: assert property (sw_reset_pulse
        |-> adv_effective[4:0] == 5'h00 && adv_apply_pulse) else $error("soft reset low bits");
    a_restart_pulse: assert property (reg_wr && reg_addr == 5'h00 && reg_wdata[9]
        |=> an_restart_pulse ##1 !an_restart_pulse) else $error("restart pulse wrong");
    a_hw_defaults: assert property ($fell(srst) |-> adv_effective ==
        {7'h00, {2{$past(pause_strap_default)}}, $past(autoneg_config_strap_bit0), 6'h20})
        else $error("hardware reset defaults wrong");
endmodule

bind fan_regs fan_regs_checker #(.OUI_LSB(OUI_LSB), .MODEL_NUM(MODEL_NUM), .REV_NUM(REV_NUM))
    u_fan_regs_checker (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pause_strap_default(pause_strap_default), .link_up(link_up),
    .autoneg_config_strap_bit0(autoneg_config_strap_bit0), .adv_effective(adv_effective),
    .media_mode(media_mode), .power_down(power_down), .sw_reset_pulse(sw_reset_pulse),
    .an_restart_pulse(an_restart_pulse), .adv_apply_pulse(adv_apply_pulse));

// ### dv/testbench.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end

module testbench;
    ////////////////////////////////////////////////////////////////////////
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic pause_strap_default = 1'b1;
    logic autoneg_config_strap_bit0 = 1'b0;
    logic link_up = 1'b1;
    logic [15:0] reg_rdata;
    logic [15:0] adv_effective;
    logic [1:0] media_mode;
    logic power_down;
    logic sw_reset_pulse;
    logic an_restart_pulse;
    logic adv_apply_pulse;
    int errors = 0;
    int checks_done = 0;

    always #5 core_clk = ~core_clk;

    fan_regs u_fan_regs (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pause_strap_default(pause_strap_default), .link_up(link_up),
        .autoneg_config_strap_bit0(autoneg_config_strap_bit0), .adv_effective(adv_effective),
        .media_mode(media_mode), .power_down(power_down), .sw_reset_pulse(sw_reset_pulse),
        .an_restart_pulse(an_restart_pulse), .adv_apply_pulse(adv_apply_pulse));
    ////////////////////////////////////////////////////////////////////////
    task hwrst(input logic p, input logic h);
        @(posedge core_clk);
        srst <= 1'b1;
        pause_strap_default <= p;
        autoneg_config_strap_bit0 <= h;
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
    endtask

    task wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask

    // Looks at the effective word just after the edge that may have applied it.
    task eff(input logic [15:0] e, input logic p);
        #1;
        `CHK(adv_effective, e)
        `CHK(adv_apply_pulse, p)
    endtask

    // Looks at the control outputs just after the edge that may have changed them.
    task ctl(input logic [1:0] m, input logic pd, input logic sr, input logic rs);
        #1;
        `CHK(media_mode, m)
        `CHK(power_down, pd)
        `CHK(sw_reset_pulse, sr)
        `CHK(an_restart_pulse, rs)
    endtask

    task finish_test;
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #200000;
        errors++;
        finish_test();
    end

    initial
    begin
        hwrst(1'b1, 1'b0);
        eff(16'h01a0, 1'b0);
        ctl(2'b01, 1'b0, 1'b0, 1'b0);
        rd(5'h03, 16'ha955);
        wr(5'h03, 16'h0000);
        rd(5'h03, 16'ha955);
        rd(5'h1f, 16'h0000);
        rd(5'h04, 16'h01a0);
        wr(5'h04, 16'hffff);
        eff(16'h01a0, 1'b0);
        rd(5'h04, 16'hb1ff);
        wr(5'h00, 16'h0200);
        eff(16'hb1ff, 1'b1);
        ctl(2'b01, 1'b0, 1'b0, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            wr(5'h04, {2'b00, i[1:0], 3'b000, i[1:0], 7'h00});
            wr(5'h00, 16'h0200);
            eff({2'b00, i[1:0], 3'b000, i[1:0], 7'h00}, 1'b1);
        end
        wr(5'h04, 16'h807f);
        wr(5'h00, 16'h8000);
        eff(16'h8060, 1'b1);
        ctl(2'b01, 1'b0, 1'b1, 1'b0);
        rd(5'h04, 16'h8060);
        wr(5'h00, 16'h0800);
        eff(16'h8060, 1'b0);
        ctl(2'b01, 1'b1, 1'b0, 1'b0);
        rd(5'h00, 16'h0800);
        wr(5'h04, 16'h2180);
        wr(5'h00, 16'h0000);
        eff(16'h2180, 1'b1);
        ctl(2'b01, 1'b0, 1'b0, 1'b0);
        wr(5'h04, 16'hb080);
        @(posedge core_clk);
        link_up <= 1'b0;
        @(posedge core_clk);
        eff(16'hb080, 1'b1);
        @(posedge core_clk);
        link_up <= 1'b1;
        wr(5'h10, 16'h0000);
        ctl(2'b00, 1'b0, 1'b0, 1'b0);
        rd(5'h04, 16'h0000);
        wr(5'h04, 16'h0020);
        wr(5'h10, 16'h0003);
        rd(5'h04, 16'h0000);
        rd(5'h10, 16'h0003);
        wr(5'h10, 16'h0001);
        rd(5'h04, 16'hb080);
        wr(5'h10, 16'h0002);
        wr(5'h00, 16'h0800);
        hwrst(1'b0, 1'b1);
        eff(16'h0060, 1'b0);
        ctl(2'b01, 1'b0, 1'b0, 1'b0);
        rd(5'h04, 16'h0060);
        finish_test();
    end
endmodule
